// ---- hdl/vwm_pkg.sv ----
// Package with object indices, defaults and timing constants of the velocity window monitor.
`default_nettype none
package vwm_pkg;
  localparam logic [15:0] IDX_ACT_VEL        = 16'h606c;
  localparam logic [15:0] IDX_MATCH_BAND     = 16'h606d;
  localparam logic [15:0] IDX_MATCH_HOLD     = 16'h606e;
  localparam logic [15:0] IDX_LOW_THRESH     = 16'h606f;
  localparam logic [15:0] IDX_LOW_HOLD       = 16'h6070;
  localparam logic [15:0] RST_MATCH_BAND     = 16'h03e8;
  localparam logic [15:0] RST_MATCH_HOLD     = 16'h0000;
  localparam logic [15:0] RST_LOW_THRESH     = 16'h0064;
  localparam logic [15:0] RST_LOW_HOLD       = 16'h0000;
  localparam logic [7:0]  CFG_MOTION_CTRL    = 8'h40;
  localparam logic [7:0]  MODE_PROFILE_VEL   = 8'h03;
  localparam int          STW_TARGET_BIT     = 10;
  localparam int          STW_SPEED_BIT      = 12;
  localparam int          CLK_HZ             = 10_000_000;
  localparam int          TICK_PERIOD_US     = 1000;
  localparam int          TICK_CYCLES        = CLK_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int          NV_COUNT           = 4;
  localparam logic [1:0]  NV_MATCH_BAND      = 2'h0;
  localparam logic [1:0]  NV_MATCH_HOLD      = 2'h1;
  localparam logic [1:0]  NV_LOW_THRESH      = 2'h2;
  localparam logic [1:0]  NV_LOW_HOLD        = 2'h3;
  typedef enum logic [2:0] {
    VWM_IDLE    = 3'b001,
    VWM_RESTORE = 3'b010,
    VWM_SAVE    = 3'b100
  } vwm_nv_state_t;
endpackage
`default_nettype wire

// ---- hdl/vwm_ms_tick.sv ----
// Millisecond tick divider producing a one-cycle enable pulse.
`default_nettype none
module vwm_ms_tick
  import vwm_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);
  logic [13:0] cnt_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 14'h0000;
      tick_o <= 1'b0;
    end else if (cnt_q == 14'(TICK_CYCLES - 1)) begin
      cnt_q  <= 14'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 14'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/vwm_hold_timer.sv ----
// Hold-time counter that reports when a condition has lasted longer than a programmed time.
`default_nettype none
module vwm_hold_timer
  import vwm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        tick_i,
  input  wire logic        cond_i,
  input  wire logic [15:0] limit_i,
  output logic             done_o
);
  logic [16:0] cnt_q;

  // The count saturates one past the limit, so a limit of 65535 still completes.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 17'h00000;
    end else if (!cond_i) begin
      cnt_q <= 17'h00000;
    end else if (tick_i && (cnt_q <= {1'b0, limit_i})) begin
      cnt_q <= cnt_q + 17'h00001;
    end
  end

  assign done_o = cond_i && (cnt_q > {1'b0, limit_i});
endmodule
`default_nettype wire

// ---- hdl/vwm_top.sv ----
// Velocity window and threshold monitor with its object dictionary and save/restore path.
`default_nettype none
module vwm_top
  import vwm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  drive_config_i,
  input  wire logic [7:0]  op_mode_i,
  input  wire logic [31:0] meas_velocity_i,
  input  wire logic [31:0] target_velocity_i,
  input  wire logic        obj_wr_i,
  input  wire logic        obj_rd_i,
  input  wire logic [15:0] obj_index_i,
  input  wire logic [31:0] obj_wdata_i,
  output logic [31:0]      obj_rdata_o,
  output logic             obj_ack_o,
  output logic             obj_err_o,
  input  wire logic        save_cmd_i,
  output logic             save_busy_o,
  output logic [31:0]      pdo_act_velocity_o,
  output logic             target_reached_o,
  output logic             speed_below_o,
  output logic [15:0]      status_bits_o,
  output logic             param_wr_o,
  output logic [1:0]       param_sel_o,
  output logic [15:0]      param_data_o,
  output logic             nv_wr_o,
  output logic [1:0]       nv_addr_o,
  output logic [15:0]      nv_wdata_o,
  input  wire logic [15:0] nv_rdata_i,
  input  wire logic        nv_valid_i
);
  logic [15:0]   match_band_q;
  logic [15:0]   match_hold_q;
  logic [15:0]   low_thresh_q;
  logic [15:0]   low_hold_q;
  logic [31:0]   act_vel_q;
  logic          reached_q;
  logic          below_q;
  logic          tick;
  logic          active;
  logic          pv_mode;
  logic          in_band;
  logic          above_thr;
  logic          band_done;
  logic          above_done;
  logic          hit_known;
  logic          hit_rw;
  logic [1:0]    hit_sel;
  logic          nv_wr_any;
  vwm_nv_state_t nv_state_q;
  logic [1:0]    nv_idx_q;
  logic          nv_req_q;
  logic [33:0]   diff;
  logic [33:0]   abs_diff;
  logic [32:0]   abs_act;

  assign active  = (drive_config_i == CFG_MOTION_CTRL);
  assign pv_mode = active && (op_mode_i == MODE_PROFILE_VEL);

  // Wide arithmetic keeps the difference of two 32-bit signed values exact.
  assign diff     = {{2{target_velocity_i[31]}}, target_velocity_i}
                  - {{2{act_vel_q[31]}}, act_vel_q};
  assign abs_diff = diff[33] ? (34'h0 - diff) : diff;
  assign abs_act  = act_vel_q[31] ? (33'h0 - {act_vel_q[31], act_vel_q})
                                  : {1'b0, act_vel_q};
  // A zero band leaves only equality, since a difference below zero is impossible.
  assign in_band  = pv_mode && ((match_band_q == 16'h0000) ? (abs_diff == 34'h0)
                  : (abs_diff < {18'h00000, match_band_q}));
  assign above_thr = pv_mode && (abs_act > {17'h00000, low_thresh_q});

  vwm_ms_tick u_tick (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick_o  (tick)
  );

  vwm_hold_timer u_band_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick_i  (tick),
    .cond_i  (in_band),
    .limit_i (match_hold_q),
    .done_o  (band_done)
  );

  vwm_hold_timer u_thr_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick_i  (tick),
    .cond_i  (above_thr),
    .limit_i (low_hold_q),
    .done_o  (above_done)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_vel_q <= 32'h00000000;
    end else if (active) begin
      act_vel_q <= meas_velocity_i;
    end
  end

  assign pdo_act_velocity_o = act_vel_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reached_q <= 1'b0;
    end else begin
      reached_q <= band_done;
    end
  end

  // Bit 12 is a hysteresis flag: quick to set below, slow to clear above.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      below_q <= 1'b1;
    end else if (!pv_mode) begin
      below_q <= 1'b0;
    end else if (abs_act < {17'h00000, low_thresh_q}) begin
      below_q <= 1'b1;
    end else if (above_done) begin
      below_q <= 1'b0;
    end
  end

  assign target_reached_o = reached_q;
  assign speed_below_o    = below_q;

  always_comb begin
    status_bits_o                 = 16'h0000;
    status_bits_o[STW_TARGET_BIT] = reached_q;
    status_bits_o[STW_SPEED_BIT]  = below_q;
  end

  always_comb begin
    hit_known = 1'b1;
    hit_rw    = 1'b1;
    hit_sel   = NV_MATCH_BAND;
    case (obj_index_i)
      IDX_ACT_VEL:    hit_rw  = 1'b0;
      IDX_MATCH_BAND: hit_sel = NV_MATCH_BAND;
      IDX_MATCH_HOLD: hit_sel = NV_MATCH_HOLD;
      IDX_LOW_THRESH: hit_sel = NV_LOW_THRESH;
      IDX_LOW_HOLD:   hit_sel = NV_LOW_HOLD;
      default: begin
        hit_known = 1'b0;
        hit_rw    = 1'b0;
      end
    endcase
  end

  // Values above 65535 are refused rather than truncated.
  logic wr_ok;
  assign wr_ok = obj_wr_i && active && hit_rw && (obj_wdata_i[31:16] == 16'h0000)
              && (nv_state_q == VWM_IDLE);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_band_q <= RST_MATCH_BAND;
      match_hold_q <= RST_MATCH_HOLD;
      low_thresh_q <= RST_LOW_THRESH;
      low_hold_q   <= RST_LOW_HOLD;
    end else if (nv_state_q == VWM_RESTORE && nv_valid_i) begin
      case (nv_idx_q)
        NV_MATCH_BAND: match_band_q <= nv_rdata_i;
        NV_MATCH_HOLD: match_hold_q <= nv_rdata_i;
        NV_LOW_THRESH: low_thresh_q <= nv_rdata_i;
        default:       low_hold_q   <= nv_rdata_i;
      endcase
    end else if (wr_ok) begin
      case (hit_sel)
        NV_MATCH_BAND: match_band_q <= obj_wdata_i[15:0];
        NV_MATCH_HOLD: match_hold_q <= obj_wdata_i[15:0];
        NV_LOW_THRESH: low_thresh_q <= obj_wdata_i[15:0];
        default:       low_hold_q   <= obj_wdata_i[15:0];
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      obj_ack_o   <= 1'b0;
      obj_err_o   <= 1'b0;
      obj_rdata_o <= 32'h00000000;
    end else begin
      obj_ack_o <= obj_wr_i || obj_rd_i;
      obj_err_o <= (obj_wr_i && !wr_ok) || (obj_rd_i && (!hit_known || !active));
      obj_rdata_o <= 32'h00000000;
      if (obj_rd_i && active) begin
        case (obj_index_i)
          IDX_ACT_VEL:    obj_rdata_o <= act_vel_q;
          IDX_MATCH_BAND: obj_rdata_o <= {16'h0000, match_band_q};
          IDX_MATCH_HOLD: obj_rdata_o <= {16'h0000, match_hold_q};
          IDX_LOW_THRESH: obj_rdata_o <= {16'h0000, low_thresh_q};
          IDX_LOW_HOLD:   obj_rdata_o <= {16'h0000, low_hold_q};
          default:        obj_rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Mirror every accepted write into the volatile drive parameter set.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      param_wr_o   <= 1'b0;
      param_sel_o  <= NV_MATCH_BAND;
      param_data_o <= 16'h0000;
    end else begin
      param_wr_o <= wr_ok;
      if (wr_ok) begin
        param_sel_o  <= hit_sel;
        param_data_o <= obj_wdata_i[15:0];
      end
    end
  end

  // Restore runs once after reset; a save request arriving meanwhile is held.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nv_req_q <= 1'b0;
    end else if (save_cmd_i) begin
      nv_req_q <= 1'b1;
    end else if (nv_state_q == VWM_IDLE) begin
      nv_req_q <= 1'b0;
    end
  end

  assign nv_wr_any = (nv_state_q == VWM_SAVE);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nv_state_q <= VWM_RESTORE;
      nv_idx_q   <= NV_MATCH_BAND;
    end else begin
      case (nv_state_q)
        VWM_IDLE: begin
          nv_idx_q <= NV_MATCH_BAND;
          if (nv_req_q && active) begin
            nv_state_q <= VWM_SAVE;
          end
        end
        VWM_RESTORE: begin
          if (nv_valid_i) begin
            nv_idx_q <= nv_idx_q + 2'h1;
            if (nv_idx_q == 2'(NV_COUNT - 1)) begin
              nv_state_q <= VWM_IDLE;
            end
          end
        end
        VWM_SAVE: begin
          nv_idx_q <= nv_idx_q + 2'h1;
          if (nv_idx_q == 2'(NV_COUNT - 1)) begin
            nv_state_q <= VWM_IDLE;
          end
        end
        default: nv_state_q <= VWM_IDLE;
      endcase
    end
  end

  always_comb begin
    nv_wr_o    = nv_wr_any;
    nv_addr_o  = nv_idx_q;
    nv_wdata_o = 16'h0000;
    case (nv_idx_q)
      NV_MATCH_BAND: nv_wdata_o = match_band_q;
      NV_MATCH_HOLD: nv_wdata_o = match_hold_q;
      NV_LOW_THRESH: nv_wdata_o = low_thresh_q;
      default:       nv_wdata_o = low_hold_q;
    endcase
  end

  assign save_busy_o = (nv_state_q != VWM_IDLE) || nv_req_q;
endmodule
`default_nettype wire

// ---- dv/vwm_chk.sv ----
// Port checker for the velocity window monitor.
`default_nettype none
module vwm_chk
  import vwm_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  drive_config_i,
  input wire logic [7:0]  op_mode_i,
  input wire logic        obj_wr_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [31:0] obj_wdata_i,
  input wire logic        obj_ack_o,
  input wire logic        obj_err_o,
  input wire logic        save_cmd_i,
  input wire logic        save_busy_o,
  input wire logic        target_reached_o,
  input wire logic        speed_below_o,
  input wire logic [15:0] status_bits_o,
  input wire logic        param_wr_o,
  input wire logic [1:0]  param_sel_o,
  input wire logic [15:0] param_data_o,
  input wire logic        nv_wr_o,
  input wire logic [1:0]  nv_addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ro_wr;
    obj_wr_i && obj_index_i == IDX_ACT_VEL |=> obj_ack_o && obj_err_o;
  endproperty
  a_ro_wr: assert property (p_ro_wr) else $error("velocity write taken");
  property p_range;
    obj_wr_i && obj_wdata_i[31:16] != 16'h0000 |=> obj_err_o && !param_wr_o;
  endproperty
  a_range: assert property (p_range) else $error("wide value taken");
  property p_mirror;
    obj_ack_o && !obj_err_o && $past(obj_wr_i) |-> param_wr_o
      && param_data_o == $past(obj_wdata_i[15:0]);
  endproperty
  a_mirror: assert property (p_mirror) else $error("no parameter copy");
  // The four writable objects sit at consecutive indices, so the select is the offset.
  property p_sel;
    param_wr_o |-> param_sel_o == 2'($past(obj_index_i) - IDX_MATCH_BAND);
  endproperty
  a_sel: assert property (p_sel) else $error("parameter select");
  property p_cfg;
    (drive_config_i != CFG_MOTION_CTRL) [*2] |-> !target_reached_o && !speed_below_o;
  endproperty
  a_cfg: assert property (p_cfg) else $error("status outside motion control");
  property p_mode;
    (op_mode_i != MODE_PROFILE_VEL) [*2] |-> !target_reached_o && !speed_below_o;
  endproperty
  a_mode: assert property (p_mode) else $error("status outside velocity mode");
  property p_map;
    status_bits_o == {3'h0, speed_below_o, 1'h0, target_reached_o, 10'h000};
  endproperty
  a_map: assert property (p_map) else $error("status word layout");
  // The save walks all four words in order so a restore finds each at its index.
  property p_save;
    save_cmd_i && !save_busy_o && drive_config_i == CFG_MOTION_CTRL
      |=> save_busy_o && !nv_wr_o
      ##1 nv_wr_o && nv_addr_o == 2'h0 ##1 nv_wr_o && nv_addr_o == 2'h1
      ##1 nv_wr_o && nv_addr_o == 2'h2 ##1 nv_wr_o && nv_addr_o == 2'h3
      ##1 !nv_wr_o && !save_busy_o;
  endproperty
  a_save: assert property (p_save) else $error("save sequence");
  property p_busy;
    obj_wr_i && save_busy_o |=> obj_err_o;
  endproperty
  a_busy: assert property (p_busy) else $error("write during store access");
endmodule
bind vwm_top vwm_chk u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .drive_config_i(drive_config_i),
  .op_mode_i(op_mode_i), .obj_wr_i(obj_wr_i), .obj_index_i(obj_index_i),
  .obj_wdata_i(obj_wdata_i), .obj_ack_o(obj_ack_o), .obj_err_o(obj_err_o),
  .save_cmd_i(save_cmd_i), .save_busy_o(save_busy_o), .target_reached_o(target_reached_o),
  .speed_below_o(speed_below_o), .status_bits_o(status_bits_o), .param_wr_o(param_wr_o),
  .param_sel_o(param_sel_o),
  .param_data_o(param_data_o), .nv_wr_o(nv_wr_o), .nv_addr_o(nv_addr_o));
`default_nettype wire

// ---- dv/vwm_nv_model.sv ----
// Non-volatile parameter store serving the monitor's restore and save accesses.
`default_nettype none
module vwm_nv_model
  import vwm_pkg::*;
#(
  parameter bit SLOW = 1'b0
)
(
  input  wire logic        clk_i,
  input  wire logic        busy_i,
  input  wire logic        wr_i,
  input  wire logic [1:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  output logic [15:0]      rdata_o,
  output logic             valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Contents survive reset, so the store has no reset input.
  logic [15:0] mem [NV_COUNT] = '{RST_MATCH_BAND, RST_MATCH_HOLD, RST_LOW_THRESH, RST_LOW_HOLD};
  logic        phase = 1'b0;
  always @(posedge clk_i) begin
    phase <= ~phase;
    if (wr_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
  // A slow store answers every other cycle; between answers the data is inverted.
  assign valid_o = busy_i && !wr_i && (phase || !SLOW);
  assign rdata_o = valid_o ? mem[addr_i] : ~mem[addr_i];
endmodule
`default_nettype wire

// ---- dv/tb_velocity_window_monitor.sv ----
// Testbench for object access, status bits and save/restore of the monitor.
`default_nettype none
module tb_velocity_window_monitor
  import vwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, wr, rd, save, ack, err, busy, tr, sb, nv_wr, nv_valid;
  logic [7:0]  cfg, mode;
  logic [15:0] idx, stw, nv_wdata, nv_rdata;
  logic [31:0] meas, tgt, wdata, rdata, pdo;
  logic [1:0]  nv_addr;
  int          n_mismatch, compares;
  vwm_top DUT (.clk_i(clk), .rst_n_i(rst_n), .drive_config_i(cfg), .op_mode_i(mode),
    .meas_velocity_i(meas), .target_velocity_i(tgt), .obj_wr_i(wr), .obj_rd_i(rd),
    .obj_index_i(idx), .obj_wdata_i(wdata), .obj_rdata_o(rdata), .obj_ack_o(ack),
    .obj_err_o(err), .save_cmd_i(save), .save_busy_o(busy), .pdo_act_velocity_o(pdo),
    .target_reached_o(tr), .speed_below_o(sb), .status_bits_o(stw), .param_wr_o(),
    .param_sel_o(), .param_data_o(), .nv_wr_o(nv_wr), .nv_addr_o(nv_addr),
    .nv_wdata_o(nv_wdata), .nv_rdata_i(nv_rdata), .nv_valid_i(nv_valid));
  vwm_nv_model #(.SLOW(1'b1)) u_nv (.clk_i(clk), .busy_i(busy), .wr_i(nv_wr),
    .addr_i(nv_addr), .wdata_i(nv_wdata), .rdata_o(nv_rdata), .valid_o(nv_valid));
  task automatic wrap_up;
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d,
                     input logic e, input logic [31:0] x);
    @(negedge clk);
    wr = w;
    rd = !w;
    idx = i;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    chk("ack", 32'h1, {31'h0, ack});
    chk("err", {31'h0, e}, {31'h0, err});
    if (!w) chk("rdata", x, rdata);
  endtask
  // Bit 16 stands for the busy flag; a wait that runs out ends the run.
  task automatic wait_st(input int b, input logic v, input int lim);
    int k;
    for (k = 0; k < lim && (b < 16 ? stw[b] : busy) !== v; k++) @(negedge clk);
    if ((b < 16 ? stw[b] : busy) !== v) begin
      chk("wait", {31'h0, v}, {31'h0, (b < 16 ? stw[b] : busy)});
      wrap_up();
    end
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    wait_st(16, 1'b0, 100);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {wr, rd, save, idx, wdata} = '0;
    cfg = CFG_MOTION_CTRL;
    mode = MODE_PROFILE_VEL;
    meas = 32'hffff_fff9;
    tgt = 32'h0;
    do_reset();
    acc(1'b0, IDX_MATCH_BAND, 32'h0, 1'b0, 32'h3e8);
    acc(1'b0, IDX_MATCH_HOLD, 32'h0, 1'b0, 32'h0);
    acc(1'b0, IDX_LOW_THRESH, 32'h0, 1'b0, 32'h64);
    acc(1'b0, IDX_LOW_HOLD, 32'h0, 1'b0, 32'h0);
    acc(1'b0, IDX_ACT_VEL, 32'h0, 1'b0, 32'hffff_fff9);
    chk("pdo", 32'hffff_fff9, pdo);
    acc(1'b1, IDX_ACT_VEL, 32'h5, 1'b1, 32'h0);
    acc(1'b1, IDX_MATCH_BAND, 32'h1_0000, 1'b1, 32'h0);
    acc(1'b1, 16'h6071, 32'h5, 1'b1, 32'h0);
    acc(1'b1, IDX_LOW_HOLD, 32'hffff, 1'b0, 32'h0);
    acc(1'b0, IDX_LOW_HOLD, 32'h0, 1'b0, 32'hffff);
    acc(1'b1, IDX_LOW_HOLD, 32'h0, 1'b0, 32'h0);
    acc(1'b1, IDX_MATCH_BAND, 32'h5, 1'b0, 32'h0);
    acc(1'b1, IDX_LOW_THRESH, 32'h14, 1'b0, 32'h0);
    acc(1'b1, IDX_MATCH_HOLD, 32'h1, 1'b0, 32'h0);
    meas = 32'h0;
    tgt = 32'h3;
    wait_st(12, 1'b1, 3);
    repeat (9990) @(negedge clk);
    chk("early", 32'h0, {31'h0, tr});
    wait_st(10, 1'b1, 10020);
    tgt = 32'h5;
    wait_st(10, 1'b0, 3);
    acc(1'b1, IDX_MATCH_BAND, 32'h0, 1'b0, 32'h0);
    acc(1'b1, IDX_MATCH_HOLD, 32'h0, 1'b0, 32'h0);
    tgt = 32'h0;
    wait_st(10, 1'b1, 10010);
    meas = 32'h1;
    wait_st(10, 1'b0, 3);
    meas = 32'hffff_ffe2;
    wait_st(12, 1'b0, 10010);
    meas = 32'hffff_ffed;
    wait_st(12, 1'b1, 3);
    tgt = 32'hffff_ffed;
    wait_st(10, 1'b1, 10010);
    mode = 8'h01;
    wait_st(12, 1'b0, 3);
    repeat (2) @(negedge clk);
    chk("mode_tr", 32'h0, {31'h0, tr});
    mode = MODE_PROFILE_VEL;
    cfg = 8'h00;
    acc(1'b1, IDX_MATCH_BAND, 32'h7, 1'b1, 32'h0);
    cfg = CFG_MOTION_CTRL;
    acc(1'b1, IDX_MATCH_BAND, 32'h1234, 1'b0, 32'h0);
    save = 1'b1;
    @(negedge clk);
    save = 1'b0;
    wait_st(16, 1'b0, 20);
    do_reset();
    acc(1'b0, IDX_MATCH_BAND, 32'h0, 1'b0, 32'h1234);
    acc(1'b0, IDX_LOW_THRESH, 32'h0, 1'b0, 32'h14);
    wrap_up();
  end
endmodule
`default_nettype wire
